// file: shared/aux_cfg_pkg.sv
// Constants and types shared by the auxiliary configuration register bank.
package aux_cfg_pkg;
   localparam logic [15:0] crc_input_byte_off = 16'h03cc;
   localparam logic [15:0] bandgap_trim_off = 16'h03d4;
   localparam logic [15:0] osc_trim_low_config_off = 16'h03d8;
   localparam logic [15:0] aux_control_two_off = 16'h03dc;
   localparam logic [15:0] aux_control_one_off = 16'h03e0;
   localparam logic [16:0] flash_config_high_word_off = 17'h1fffc;
   localparam logic [15:0] irq_status_off = 16'h0400;
   localparam logic [15:0] irq_enable_off = 16'h0404;
   localparam logic [15:0] irq_clear_off = 16'h0408;
   localparam logic [15:0] event_status_off = 16'h040c;
   localparam int crc_index = 32'hf3;
   localparam int bandgap_index = 32'hf5;
   localparam int osc_index = 32'hf6;
   localparam int aux_two_index = 32'hf7;
   localparam int aux_one_index = 32'hf8;
   localparam int flash_cfg_index = 32'h7fff;
   localparam logic [7:0] osc_trim_low_config_rst = 8'h00;
   localparam logic [7:0] aux_control_two_rst = 8'h00;
   localparam logic [7:0] aux_control_one_rst = 8'h00;
   localparam logic [7:0] bandgap_trim_rst = 8'h00;
   localparam int osc_trim_lsb = 0;
   localparam int watchdog_mode_lsb = 6;
   localparam int low_power_saving_bit = 7;
   localparam int watchdog_clear_bit = 7;
   localparam int timer_three_clear_bit = 6;
   localparam int touch_start_bit = 5;
   localparam int adc_start_bit = 4;
   localparam int reference_out_bit = 4;
   localparam int wide_divide_bit = 3;
   localparam int prog_wdt_lsb = 1;
   localparam int wide_muldiv_bit = 0;
   localparam int brownout_disable_bit = 3;
   localparam int timer_two_sel_bit = 2;
   localparam int timer_one_sel_bit = 1;
   localparam int pointer_bank_bit = 0;
   localparam int code_protect_bit = 7;
   localparam int ext_reset_bit = 6;
   localparam int level_lsb = 3;
   localparam int locked_area_bit = 1;
   localparam int osc_select_bit = 0;
   localparam int clk_mhz = 10;
   localparam real prog_wdt_time_1_ms = 0.8;
   localparam real prog_wdt_time_2_ms = 3.2;
   localparam real prog_wdt_time_3_ms = 6.4;
   localparam int prog_wdt_cycles_1 =
      int'(prog_wdt_time_1_ms * 1000.0) * clk_mhz;
   localparam int prog_wdt_cycles_2 =
      int'(prog_wdt_time_2_ms * 1000.0) * clk_mhz;
   localparam int prog_wdt_cycles_3 =
      int'(prog_wdt_time_3_ms * 1000.0) * clk_mhz;
   localparam int irq_bits = 3;
   typedef enum logic [2:0]
   {
      wdt_off = 3'b001,
      wdt_active_only = 3'b010,
      wdt_always = 3'b100
   } watchdog_mode_t;
   typedef enum logic [3:0]
   {
      pw_off = 4'b0001,
      pw_short = 4'b0010,
      pw_mid = 4'b0100,
      pw_long = 4'b1000
   } prog_wdt_t;
endpackage

// file: verilog/strobe_hold.sv
// Start flag held until the finishing event or a software clear.
`timescale 1ns/10ps
module strobe_hold
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set_pulse,
   input wire logic sw_clear,
   input wire logic done_pulse,
   output logic flag
);
   import aux_cfg_pkg::*;
   logic flag_next;

   // A start in the same cycle as a finish wins, so no request is lost.
   always_comb
   begin
      flag_next = flag;
      if (sw_clear || done_pulse)
      begin
         flag_next = 1'b0;
      end
      if (set_pulse)
      begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flag <= 1'b0;
      end
      else
      begin
         flag <= flag_next;
      end
   end
endmodule

// file: verilog/prog_watchdog.sv
// Timeout counter for the in-application-programming watchdog.
`timescale 1ns/10ps
module prog_watchdog
#(
   parameter int cycles_1 = aux_cfg_pkg::prog_wdt_cycles_1,
   parameter int cycles_2 = aux_cfg_pkg::prog_wdt_cycles_2,
   parameter int cycles_3 = aux_cfg_pkg::prog_wdt_cycles_3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] sel,
   input wire logic restart,
   output logic timeout
);
   import aux_cfg_pkg::*;
   logic [17:0] count_reg;
   logic [17:0] limit;

   if (cycles_1 < 1 || cycles_3 >= (1 << 18))
   begin
      $error("prog_watchdog: timeout count out of range");
   end

   always_comb
   begin
      case (sel)
         2'h1: limit = 18'(cycles_1);
         2'h2: limit = 18'(cycles_2);
         2'h3: limit = 18'(cycles_3);
         default: limit = 18'h3ffff;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || sel == 2'h0 || restart)
      begin
         count_reg <= 18'h00000;
         timeout <= 1'b0;
      end
      else if (count_reg + 18'h00001 >= limit)
      begin
         timeout <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 18'h00001;
         timeout <= 1'b0;
      end
   end
endmodule

// file: verilog/system_aux_config_regs.sv
// Auxiliary system configuration register bank behind AXI4-Lite.
`timescale 1ns/10ps
module system_aux_config_regs
#(
   parameter int prog_cycles_1 = aux_cfg_pkg::prog_wdt_cycles_1,
   parameter int prog_cycles_2 = aux_cfg_pkg::prog_wdt_cycles_2,
   parameter int prog_cycles_3 = aux_cfg_pkg::prog_wdt_cycles_3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [16:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [16:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] flash_cfg_word,
   input wire logic reference_enable,
   input wire logic sleep_mode,
   input wire logic adc_done,
   input wire logic touch_done,
   input wire logic timer_one_counter_mode,
   input wire logic timer_two_counter_mode,
   input wire logic timer_one_pin,
   input wire logic timer_two_pin,
   input wire logic slow_clock_div16,
   output logic [6:0] osc_freq_trim,
   output logic [3:0] reference_trim,
   output logic [2:0] watchdog_mode,
   output logic watchdog_run,
   output logic watchdog_clear_strobe,
   output logic timer_three_clear_strobe,
   output logic adc_conv_start,
   output logic touch_conv_start,
   output logic brownout_enable,
   output logic reference_to_pin,
   output logic [1:0] muldiv_mode,
   output logic program_watchdog_timeout,
   output logic timer_one_count_in,
   output logic timer_two_count_in,
   output logic pointer_bank_sel,
   output logic code_protect,
   output logic ext_reset_pin_en,
   output logic [2:0] brownout_level_sel,
   output logic locked_area_limited,
   output logic osc_freq_select,
   output logic irq
);
   import aux_cfg_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   logic [7:0] osc_reg;
   logic [7:0] aux_two_reg;
   logic [7:0] aux_one_reg;
   logic [7:0] bandgap_reg;
   logic [7:0] crc_feed_byte_reg;
   logic [7:0] flash_cfg_reg;
   logic cfg_captured_reg;
   logic [irq_bits-1:0] irq_status_reg;
   logic [irq_bits-1:0] irq_enable_reg;
   logic [16:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_have_reg;
   logic wr_go;
   logic wr_lane0;
   logic wr_ok;
   logic [7:0] wbyte;
   logic adc_flag;
   logic touch_flag;
   logic pw_timeout;
   logic pw_timeout_d_reg;
   logic [irq_bits-1:0] events;
   logic [31:0] rd_word;
   logic rd_ok;

   function automatic logic hit(input logic [16:0] a, input logic [15:0] off);
      hit = (a[16:2] == {1'b0, off[15:2]}) || (a == 17'(off));
   endfunction

   function automatic logic is_cfg(input logic [16:0] a);
      is_cfg = (a[16:2] == 15'(flash_cfg_index));
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Write path takes address and data in either order.
   assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wr_lane0 = wr_go && w_strb_reg[0];
   assign wbyte = w_data_reg[7:0];

   always_comb
   begin
      wr_ok = hit(aw_addr_reg, crc_input_byte_off) ||
         hit(aw_addr_reg, bandgap_trim_off) ||
         hit(aw_addr_reg, osc_trim_low_config_off) ||
         hit(aw_addr_reg, aux_control_two_off) ||
         hit(aw_addr_reg, aux_control_one_off) ||
         hit(aw_addr_reg, irq_enable_off) ||
         hit(aw_addr_reg, irq_clear_off);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 17'h00000;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (wr_go)
      begin
         aw_have_reg <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else if (wr_go)
      begin
         w_have_reg <= 1'b0;
      end
      else
      begin
         s_axi_wready <= !w_have_reg && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_reg <= osc_trim_low_config_rst;
         bandgap_reg <= bandgap_trim_rst;
         crc_feed_byte_reg <= 8'h00;
         aux_one_reg <= aux_control_one_rst;
      end
      else if (wr_lane0)
      begin
         if (hit(aw_addr_reg, osc_trim_low_config_off))
         begin
            osc_reg <= wbyte;
         end
         if (hit(aw_addr_reg, bandgap_trim_off))
         begin
            bandgap_reg <= {4'h0, wbyte[3:0]};
         end
         if (hit(aw_addr_reg, crc_input_byte_off))
         begin
            crc_feed_byte_reg <= wbyte;
         end
         if (hit(aw_addr_reg, aux_control_one_off))
         begin
            aux_one_reg <= wbyte;
         end
      end
   end

   // Strobe bits live for exactly one cycle after the write.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aux_two_reg <= aux_control_two_rst;
      end
      else
      begin
         aux_two_reg[watchdog_clear_bit] <= 1'b0;
         aux_two_reg[timer_three_clear_bit] <= 1'b0;
         if (wr_lane0 && hit(aw_addr_reg, aux_control_two_off))
         begin
            aux_two_reg <= wbyte;
         end
      end
   end

   strobe_hold adc_hold
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_pulse(wr_lane0 && hit(aw_addr_reg, aux_control_two_off) &&
         wbyte[adc_start_bit]),
      .sw_clear(wr_lane0 && hit(aw_addr_reg, aux_control_two_off) &&
         !wbyte[adc_start_bit]),
      .done_pulse(adc_done),
      .flag(adc_flag)
   );

   strobe_hold touch_hold
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_pulse(wr_lane0 && hit(aw_addr_reg, aux_control_two_off) &&
         wbyte[touch_start_bit]),
      .sw_clear(wr_lane0 && hit(aw_addr_reg, aux_control_two_off) &&
         !wbyte[touch_start_bit]),
      .done_pulse(touch_done),
      .flag(touch_flag)
   );

   prog_watchdog #(
      .cycles_1(prog_cycles_1),
      .cycles_2(prog_cycles_2),
      .cycles_3(prog_cycles_3)
   ) prog_wdt
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(aux_two_reg[prog_wdt_lsb +: 2]),
      .restart(aux_two_reg[watchdog_clear_bit]),
      .timeout(pw_timeout)
   );

   // The word is taken while reset is held and at the first edge after release, so it applies from the start.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_captured_reg <= 1'b0;
      end
      else
      begin
         cfg_captured_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!cfg_captured_reg)
      begin
         flash_cfg_reg <= flash_cfg_word;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   assign events = {pw_timeout && !pw_timeout_d_reg, touch_done, adc_done};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_status_reg <= '0;
         irq_enable_reg <= '0;
         pw_timeout_d_reg <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         pw_timeout_d_reg <= pw_timeout;
         if (wr_lane0 && hit(aw_addr_reg, irq_enable_off))
         begin
            irq_enable_reg <= wbyte[irq_bits-1:0];
         end
         // A new event beats a clear in the same cycle.
         if (wr_lane0 && hit(aw_addr_reg, irq_clear_off))
         begin
            irq_status_reg <= (irq_status_reg & ~wbyte[irq_bits-1:0]) |
               events;
         end
         else
         begin
            irq_status_reg <= irq_status_reg | events;
         end
         irq <= |(irq_status_reg & irq_enable_reg);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      rd_ok = 1'b1;
      rd_word = 32'h00000000;
      if (hit(s_axi_araddr, bandgap_trim_off))
         rd_word[7:0] = bandgap_reg;
      else if (hit(s_axi_araddr, osc_trim_low_config_off))
         rd_word[7:0] = osc_reg;
      else if (hit(s_axi_araddr, aux_control_two_off))
         rd_word[7:0] = {aux_two_reg[7:6], touch_flag, adc_flag,
            aux_two_reg[3:0]};
      else if (hit(s_axi_araddr, aux_control_one_off))
         rd_word[7:0] = aux_one_reg;
      else if (is_cfg(s_axi_araddr))
         rd_word[7:0] = flash_cfg_reg;
      else if (hit(s_axi_araddr, irq_status_off))
         rd_word[irq_bits-1:0] = irq_status_reg;
      else if (hit(s_axi_araddr, irq_enable_off))
         rd_word[irq_bits-1:0] = irq_enable_reg;
      else if (hit(s_axi_araddr, event_status_off))
         rd_word[3:0] = {sleep_mode, pw_timeout, touch_flag, adc_flag};
      else
         rd_ok = hit(s_axi_araddr, crc_input_byte_off) ||
            hit(s_axi_araddr, irq_clear_off);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
      begin
         s_axi_arready <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_freq_trim <= 7'h00;
         reference_trim <= 4'h0;
         watchdog_mode <= wdt_off;
         watchdog_run <= 1'b0;
         watchdog_clear_strobe <= 1'b0;
         timer_three_clear_strobe <= 1'b0;
         adc_conv_start <= 1'b0;
         touch_conv_start <= 1'b0;
         brownout_enable <= 1'b1;
         reference_to_pin <= 1'b0;
         muldiv_mode <= 2'h0;
         program_watchdog_timeout <= 1'b0;
         timer_one_count_in <= 1'b0;
         timer_two_count_in <= 1'b0;
         pointer_bank_sel <= 1'b0;
      end
      else
      begin
         osc_freq_trim <= osc_reg[6:0];
         reference_trim <= bandgap_reg[3:0];
         case (osc_reg[watchdog_mode_lsb +: 2])
            2'h2:
            begin
               watchdog_mode <= wdt_active_only;
               watchdog_run <= !sleep_mode;
            end
            2'h3:
            begin
               watchdog_mode <= wdt_always;
               watchdog_run <= 1'b1;
            end
            default:
            begin
               watchdog_mode <= wdt_off;
               watchdog_run <= 1'b0;
            end
         endcase
         watchdog_clear_strobe <= aux_two_reg[watchdog_clear_bit];
         timer_three_clear_strobe <= aux_two_reg[timer_three_clear_bit];
         adc_conv_start <= adc_flag;
         touch_conv_start <= touch_flag;
         brownout_enable <= !aux_one_reg[brownout_disable_bit] &&
            !(osc_reg[low_power_saving_bit] && sleep_mode);
         reference_to_pin <= aux_two_reg[reference_out_bit] &&
            reference_enable;
         // Bit 1 is wide mode, bit 0 the 32/16 divide, gated by wide mode.
         muldiv_mode <= {aux_two_reg[wide_muldiv_bit],
            aux_two_reg[wide_muldiv_bit] &&
            aux_two_reg[wide_divide_bit]};
         program_watchdog_timeout <= pw_timeout;
         timer_one_count_in <= timer_one_counter_mode &&
            (aux_one_reg[timer_one_sel_bit] ? slow_clock_div16 :
            timer_one_pin);
         timer_two_count_in <= timer_two_counter_mode &&
            (aux_one_reg[timer_two_sel_bit] ? slow_clock_div16 :
            timer_two_pin);
         pointer_bank_sel <= aux_one_reg[pointer_bank_bit];
      end
   end

   // Straps come from the latched word, so they follow the input word while reset is held.
   always_ff @(posedge aclk)
   begin
      code_protect <= !flash_cfg_reg[code_protect_bit];
      ext_reset_pin_en <= !flash_cfg_reg[ext_reset_bit];
      brownout_level_sel <= flash_cfg_reg[level_lsb +: 3];
      locked_area_limited <= !flash_cfg_reg[locked_area_bit];
      osc_freq_select <= flash_cfg_reg[osc_select_bit];
   end
endmodule

// file: dv/system_aux_config_regs_properties.sv
// Concurrent checks on the auxiliary configuration register bank.
`timescale 1ns/10ps
module system_aux_config_regs_properties
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wvalid,
   input wire logic [7:0] flash_cfg_word,
   input wire logic reference_enable,
   input wire logic adc_done,
   input wire logic touch_done,
   input wire logic watchdog_clear_strobe,
   input wire logic timer_three_clear_strobe,
   input wire logic adc_conv_start,
   input wire logic touch_conv_start,
   input wire logic reference_to_pin,
   input wire logic code_protect,
   input wire logic ext_reset_pin_en,
   input wire logic [2:0] brownout_level_sel,
   input wire logic locked_area_limited
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   a_wdclr_pulse:
      assert property (watchdog_clear_strobe |=> !watchdog_clear_strobe)
         else $error("strobe too long");
   a_wdclr_cause:
      assert property ($rose(watchdog_clear_strobe) |-> $past(s_axi_wvalid)
         || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
         else $error("strobe with no write");
   a_t3clr_pulse:
      assert property (timer_three_clear_strobe |=> !timer_three_clear_strobe)
         else $error("timer clear too long");
   a_ref_gate:
      assert property (!reference_enable [*3] |-> !reference_to_pin)
         else $error("reference without enable");
   // A window of four quiet cycles covers the register and output stages.
   a_adc_hold:
      assert property ((!adc_done && !s_axi_wvalid) [*4]
         ##0 $past(adc_conv_start) |-> adc_conv_start)
         else $error("adc start lost");
   a_touch_hold:
      assert property ((!touch_done && !s_axi_wvalid) [*4]
         ##0 $past(touch_conv_start) |-> touch_conv_start)
         else $error("touch start lost");
   a_strap_map:
      assert property ($past(aresetn, 3) |-> code_protect == !flash_cfg_word[7]
         && ext_reset_pin_en == !flash_cfg_word[6]
         && brownout_level_sel == flash_cfg_word[5:3]
         && locked_area_limited == !flash_cfg_word[1])
         else $error("strap output wrong");
   a_strap_hold:
      assert property ($past(aresetn, 3) |-> $stable(code_protect)
         && $stable(ext_reset_pin_en) && $stable(brownout_level_sel))
         else $error("strap output moved");
endmodule

// file: dv/system_aux_config_regs_tb.sv
// Self-checking testbench for the auxiliary configuration register bank.
`timescale 1ns/10ps
module system_aux_config_regs_tb import aux_cfg_pkg::*;
;
   localparam int a_osc = osc_index * 4;
   localparam int a_two = aux_two_index * 4;
   localparam int a_one = aux_one_index * 4;
   localparam int a_cfg = flash_cfg_index * 4;
   localparam int pcyc [3] = '{16, 64, 128};
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, reference_enable;
   logic sleep_mode, adc_done, touch_done, timer_one_counter_mode;
   logic timer_two_counter_mode, timer_one_pin, timer_two_pin, irq;
   logic slow_clock_div16, watchdog_run, watchdog_clear_strobe;
   logic timer_three_clear_strobe, adc_conv_start, touch_conv_start;
   logic brownout_enable, reference_to_pin, program_watchdog_timeout;
   logic timer_one_count_in, timer_two_count_in, pointer_bank_sel;
   logic code_protect, ext_reset_pin_en, locked_area_limited;
   logic osc_freq_select;
   logic [16:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, reference_trim;
   logic [1:0] s_axi_bresp, s_axi_rresp, muldiv_mode;
   logic [7:0] flash_cfg_word;
   logic [6:0] osc_freq_trim;
   logic [2:0] watchdog_mode, brownout_level_sel;
   int errors, compares, wd_hi, t3_hi;
   // Short watchdog counts keep the run brief; ratios match 0.8/3.2/6.4.
   system_aux_config_regs #(.prog_cycles_1(16), .prog_cycles_2(64),
      .prog_cycles_3(128)) system_aux_config_regs_i (.*);
   initial
   begin
      aclk = 0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      wd_hi += int'(watchdog_clear_strobe);
      t3_hi += int'(timer_three_clear_strobe);
   end
   ////////////////////////////////////////
   task automatic close_out;
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input int a, input logic [7:0] d, input logic [1:0] r);
      s_axi_awaddr <= 17'(a);
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
      end
      while (!s_axi_bvalid);
      chk(s_axi_bresp, r);
   endtask
   task automatic rc(input int a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= 17'(a);
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   task automatic done(input bit t);
      if (t)
         touch_done <= 1;
      else
         adc_done <= 1;
      @(posedge aclk);
      touch_done <= 0;
      adc_done <= 0;
      repeat (3) @(posedge aclk);
   endtask
   ////////////////////////////////////////
   task automatic t_osc;
      logic [7:0] d;
      for (int m = 0; m < 8; m++)
      begin
         d = {m[2:1], m[0] ? 6'h3f : 6'h00};
         sleep_mode <= m[0];
         wr(a_osc, d, 0);
         repeat (3) @(posedge aclk);
         chk(osc_freq_trim, d[6:0]);
         chk(watchdog_mode, m[2] ? (m[1] ? 3'b100 : 3'b010) : 3'b001);
         chk(watchdog_run, m[2] & (m[1] | !m[0]));
         chk(brownout_enable, !(m[2] & m[0]));
      end
      sleep_mode <= 0;
      wr(a_osc, 0, 0);
   endtask
   task automatic t_two;
      for (int k = 0; k < 4; k++)
      begin
         wr(a_two, {4'h0, k[1], 2'b00, k[0]}, 0);
         repeat (3) @(posedge aclk);
         chk(muldiv_mode, {k[0], k[0] & k[1]});
      end
   endtask
   task automatic t_strobe;
      for (int i = 0; i < 2; i++)
      begin
         wd_hi = 0;
         t3_hi = 0;
         wr(a_two, i ? 8'h40 : 8'h80, 0);
         repeat (4) @(posedge aclk);
         chk(wd_hi, !i);
         chk(t3_hi, i);
         rc(a_two, 0, 0);
      end
   endtask
   task automatic t_start;
      reference_enable <= 0;
      wr(irq_enable_off, 8'h01, 0);
      wr(a_two, 8'h30, 0);
      repeat (6) @(posedge aclk);
      chk(adc_conv_start, 1);
      chk(touch_conv_start, 1);
      chk(reference_to_pin, 0);
      reference_enable <= 1;
      repeat (3) @(posedge aclk);
      chk(reference_to_pin, 1);
      done(0);
      chk(adc_conv_start, 0);
      chk(touch_conv_start, 1);
      chk(irq, 1);
      done(1);
      chk(touch_conv_start, 0);
      wr(irq_clear_off, 8'h01, 0);
      rc(irq_status_off, 2, 0);
      chk(irq, 0);
      wr(irq_enable_off, 0, 0);
      done(0);
      chk(irq, 0);
      wr(irq_clear_off, 8'h07, 0);
      wr(a_two, 8'h30, 0);
      wr(a_two, 0, 0);
      repeat (3) @(posedge aclk);
      chk(adc_conv_start, 0);
      chk(touch_conv_start, 0);
   endtask
   task automatic t_prog;
      int n;
      for (int s = 1; s < 4; s++)
      begin
         n = 0;
         wr(a_two, 8'(s << 1), 0);
         while (!program_watchdog_timeout)
         begin
            @(posedge aclk);
            n++;
         end
         chk(n > pcyc[s - 1] - 6 && n < pcyc[s - 1] + 6, 1);
         rc(event_status_off, 32'h4, 0);
         wr(a_two, 0, 0);
         repeat (3) @(posedge aclk);
         chk(program_watchdog_timeout, 0);
      end
      rc(irq_status_off, 32'h4, 0);
   endtask
   task automatic t_one;
      logic [7:0] d;
      for (int k = 0; k < 8; k++)
      begin
         d = {4'h0, k[0], k[1], k[0], k[1]};
         timer_one_pin <= k[2];
         timer_two_pin <= k[2];
         slow_clock_div16 <= !k[2];
         wr(a_one, d, 0);
         repeat (3) @(posedge aclk);
         chk(brownout_enable, !k[0]);
         chk(timer_two_count_in, k[1] ^ k[2]);
         chk(timer_one_count_in, k[0] ^ k[2]);
         chk(pointer_bank_sel, k[1]);
         rc(a_one, d, 0);
      end
      wr(a_one, 0, 0);
   endtask
   task automatic t_map;
      rc(17'h100, 0, 2);
      wr(17'h100, 8'h55, 2);
      wr(a_cfg, 8'h55, 2);
      rc(a_cfg, flash_cfg_word, 0);
      wr(crc_input_byte_off, 8'h12, 0);
      rc(crc_input_byte_off, 0, 0);
      wr(bandgap_trim_off, 8'h5a, 0);
      rc(bandgap_trim_off, 32'ha, 0);
      chk(reference_trim, 4'ha);
   endtask
   task automatic t_strap;
      for (int i = 0; i < 2; i++)
      begin
         aresetn <= 0;
         flash_cfg_word <= i ? 8'hff : 8'h00;
         repeat (3) @(posedge aclk);
         aresetn <= 1;
         repeat (4) @(posedge aclk);
         chk(code_protect, !i);
         chk(ext_reset_pin_en, !i);
         chk(brownout_level_sel, i ? 3'b111 : 3'b000);
         chk(locked_area_limited, !i);
         chk(osc_freq_select, i);
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, reference_enable} = '0;
      {sleep_mode, adc_done, touch_done, timer_one_pin, timer_two_pin} = '0;
      {s_axi_bready, s_axi_rready, timer_one_counter_mode} = '1;
      timer_two_counter_mode = 1;
      slow_clock_div16 = 0;
      s_axi_awaddr = 0;
      s_axi_araddr = 0;
      s_axi_wdata = 0;
      s_axi_wstrb = 4'hf;
      flash_cfg_word = 8'ha6;
      aresetn = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk(watchdog_mode, 3'b001);
      rc(a_one, 0, 0);
      t_osc;
      t_two;
      t_strobe;
      t_start;
      t_prog;
      t_one;
      t_map;
      t_strap;
      close_out;
   end
   initial
   begin
      #5000000;
      errors++;
      close_out;
   end
endmodule
bind system_aux_config_regs system_aux_config_regs_properties
   system_aux_config_regs_properties_i (.*);
